// *** cts_pkg.sv ***
// constants and types shared by the conditional table selector
`default_nettype none
package cts_pkg;
    // slot, condition and table counts, data and field widths
    localparam int NUM_SLOTS = 3;
    localparam int NUM_CONDS = 3;
    localparam int NUM_LUTS = 8;
    localparam int DATA_W = 16;
    localparam int SRC_W = 4;
    localparam int INST_W = 3;
    localparam int LUT_W = 3;

    // argument source encodings
    localparam logic [SRC_W-1:0] SRC_NOT_USED = 4'h0;
    localparam logic [SRC_W-1:0] SRC_CONSTANT = 4'hF;

    // comparison operators
    typedef enum logic [2:0] {
        CMP_EQ = 3'h0,
        CMP_NE = 3'h1,
        CMP_GT = 3'h2,
        CMP_GE = 3'h3,
        CMP_LT = 3'h4,
        CMP_LE = 3'h5
    } cts_cmp_type;

    // condition results
    typedef enum logic [1:0] {
        RES_FALSE = 2'h0,
        RES_TRUE = 2'h1,
        RES_ERROR = 2'h2,
        RES_NA = 2'h3
    } cts_res_type;

    // slot combiner modes
    typedef enum logic [2:0] {
        CMB_DEFAULT = 3'h0,
        CMB_AND_ALL = 3'h1,
        CMB_OR_ALL = 3'h2,
        CMB_AND_OR = 3'h3,
        CMB_OR_AND = 3'h4
    } cts_cmb_type;

    // register map, word offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h01;
    localparam logic [7:0] REG_SLOT_BASE = 8'h10;
    localparam logic [7:0] REG_COND_BASE = 8'h20;
    localparam logic [7:0] REG_CONST_BASE = 8'h40;

    // condition register field positions
    localparam int F_SRC1_LSB = 0;
    localparam int F_INST1_LSB = 4;
    localparam int F_SRC2_LSB = 8;
    localparam int F_INST2_LSB = 12;
    localparam int F_OP_LSB = 16;

    // reset values
    localparam logic [2:0] LUT_RST_A0 = 3'h0;
    localparam logic [2:0] LUT_RST_B0 = 3'h3;
    localparam logic [1:0] SLOT_NONE = 2'h3;
endpackage
`default_nettype wire

// *** cts_cond_eval.sv ***
// one condition comparator producing a two-bit result
`default_nettype none
module cts_cond_eval (
    input wire logic [cts_pkg::SRC_W-1:0] src1_in,
    input wire logic [cts_pkg::SRC_W-1:0] src2_in,
    input wire logic [2:0] op_in,
    input wire logic [cts_pkg::DATA_W-1:0] arg1_in,
    input wire logic arg1_err_in,
    input wire logic [cts_pkg::DATA_W-1:0] arg2_in,
    input wire logic arg2_err_in,
    output logic [1:0] result_out
);
    // unused arguments and error states override the compare
    wire logic unused = (src1_in == cts_pkg::SRC_NOT_USED) ||
        (src2_in == cts_pkg::SRC_NOT_USED);
    wire logic errored = arg1_err_in || arg2_err_in;
    logic hit;

    // argument one compared against argument two
    always_comb begin
        unique case (op_in)
            cts_pkg::CMP_EQ: hit = arg1_in == arg2_in;
            cts_pkg::CMP_NE: hit = arg1_in != arg2_in;
            cts_pkg::CMP_GT: hit = arg1_in > arg2_in;
            cts_pkg::CMP_GE: hit = arg1_in >= arg2_in;
            cts_pkg::CMP_LT: hit = arg1_in < arg2_in;
            cts_pkg::CMP_LE: hit = arg1_in <= arg2_in;
            default: hit = 1'b0;
        endcase
    end

    // result encoding, not-used first
    assign result_out = unused ? cts_pkg::RES_NA :
        errored ? cts_pkg::RES_ERROR :
        hit ? cts_pkg::RES_TRUE : cts_pkg::RES_FALSE;
endmodule
`default_nettype wire

// *** cts_selector.sv ***
// conditional table selector: slot logic, registers, output mirror
// Operation
// - three slots, each any of eight tables
// - active slot's table output passed unchanged
// - runs only when enabled; reset disabled
// - slots evaluated ascending, first qualifying wins
// - default slot selected at once
// - three conditions per slot, own settings
// - argument one is a block output
// - argument two is block output or constant
// - operator codes equal through less-or-equal
// - operator resets equal; changes need valid sources
// - sources reset not-used; gives not-applicable
// - result false, true, error, not-applicable
// - combiner codes default, and, or, mixed
// - all-and: false/error reject, n/a true
// - all-or: any true selects
// - mode 3: (c1 and c2) or c3
// - mode 4: (c1 or c2) and c3
// - reset combiners and, and, default
// - reset tables per logic block number
// - table without axis source gives not available
// - no interpolation, exact mirror
`default_nettype none
module cts_selector #(
    parameter int BLOCK_NUM = 1
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    // flattened block outputs indexed by (low bit of type)*8+instance
    input wire logic [16*cts_pkg::DATA_W-1:0] src_data_in,
    input wire logic [15:0] src_err_in,
    // lookup table outputs and axis-configured flags
    input wire logic [cts_pkg::NUM_LUTS*cts_pkg::DATA_W-1:0] lut_data_in,
    input wire logic [cts_pkg::NUM_LUTS-1:0] lut_axis_ok_in,
    output logic [cts_pkg::DATA_W-1:0] logic_out,
    output logic logic_avail_out,
    output logic [1:0] active_slot_out
);
    localparam int NC = cts_pkg::NUM_SLOTS * cts_pkg::NUM_CONDS;
    localparam int DW = cts_pkg::DATA_W;

    // configuration and output state
    logic enable_ff;
    logic [2:0] lut_sel_ff [cts_pkg::NUM_SLOTS];
    logic [2:0] cmb_ff [cts_pkg::NUM_SLOTS];
    logic [cts_pkg::SRC_W-1:0] src1_ff [NC];
    logic [cts_pkg::INST_W-1:0] inst1_ff [NC];
    logic [cts_pkg::SRC_W-1:0] src2_ff [NC];
    logic [cts_pkg::INST_W-1:0] inst2_ff [NC];
    logic [2:0] op_ff [NC];
    logic [DW-1:0] const_ff [NC];
    logic [DW-1:0] out_ff;
    logic avail_ff;
    logic [1:0] slot_ff;

    // fetch one block output from the flattened source bus
    function automatic logic [DW-1:0] pick_src(
        input logic [16*cts_pkg::DATA_W-1:0] bus,
        input logic [3:0] idx
    );
        pick_src = bus[idx*DW +: DW];
    endfunction

    // source index: low bit of type with instance, four bits
    function automatic logic [3:0] src_index(
        input logic [cts_pkg::SRC_W-1:0] src,
        input logic [cts_pkg::INST_W-1:0] inst
    );
        src_index = {src[0], inst};
    endfunction

    // condition is a true result
    function automatic logic is_true(input logic [1:0] r);
        is_true = (r == cts_pkg::RES_TRUE);
    endfunction

    // slot qualification by combiner mode
    function automatic logic slot_hit(
        input logic [2:0] mode,
        input logic [1:0] c1,
        input logic [1:0] c2,
        input logic [1:0] c3
    );
        logic p1;
        logic p2;
        logic p3;
        p1 = is_true(c1) || (c1 == cts_pkg::RES_NA);
        p2 = is_true(c2) || (c2 == cts_pkg::RES_NA);
        p3 = is_true(c3) || (c3 == cts_pkg::RES_NA);
        unique case (mode)
            cts_pkg::CMB_DEFAULT: slot_hit = 1'b1;
            cts_pkg::CMB_AND_ALL: slot_hit = p1 && p2 && p3;
            cts_pkg::CMB_OR_ALL:
                slot_hit = is_true(c1) || is_true(c2) || is_true(c3);
            cts_pkg::CMB_AND_OR:
                slot_hit = (is_true(c1) && is_true(c2)) || is_true(c3);
            cts_pkg::CMB_OR_AND:
                slot_hit = (is_true(c1) || is_true(c2)) && is_true(c3);
            default: slot_hit = 1'b0;
        endcase
    endfunction

    // per-condition argument fetch and compare
    logic [1:0] cres [NC];
    genvar gc;
    generate
        for (gc = 0; gc < NC; gc++) begin : g_cond
            wire logic [3:0] i1 = src_index(src1_ff[gc], inst1_ff[gc]);
            wire logic [3:0] i2 = src_index(src2_ff[gc], inst2_ff[gc]);
            wire logic c2k = (src2_ff[gc] == cts_pkg::SRC_CONSTANT);
            wire logic [DW-1:0] a1 = pick_src(src_data_in, i1);
            wire logic [DW-1:0] a2 = c2k ? const_ff[gc] :
                pick_src(src_data_in, i2);
            wire logic e2 = c2k ? 1'b0 : src_err_in[i2];
            cts_cond_eval u_eval (
                .src1_in(src1_ff[gc]),
                .src2_in(src2_ff[gc]),
                .op_in(op_ff[gc]),
                .arg1_in(a1),
                .arg1_err_in(src_err_in[i1]),
                .arg2_in(a2),
                .arg2_err_in(e2),
                .result_out(cres[gc])
            );
        end
    endgenerate

    // slot qualification
    logic [cts_pkg::NUM_SLOTS-1:0] hit;
    genvar gs;
    generate
        for (gs = 0; gs < cts_pkg::NUM_SLOTS; gs++) begin : g_slot
            assign hit[gs] = slot_hit(cmb_ff[gs], cres[gs*3],
                cres[gs*3+1], cres[gs*3+2]);
        end
    endgenerate

    // ascending priority, lowest qualifying slot wins
    wire logic [1:0] nxt_slot = hit[0] ? 2'h0 :
        hit[1] ? 2'h1 : hit[2] ? 2'h2 : cts_pkg::SLOT_NONE;
    wire logic any_hit = |hit;
    wire logic [2:0] sel_lut = any_hit ? lut_sel_ff[nxt_slot] : 3'h0;
    wire logic [DW-1:0] nxt_out = lut_data_in[sel_lut*DW +: DW];
    wire logic nxt_avail = enable_ff && any_hit &&
        lut_axis_ok_in[sel_lut];

    // output mirror, refreshed every cycle
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            out_ff <= '0;
            avail_ff <= 1'b0;
            slot_ff <= cts_pkg::SLOT_NONE;
        end else begin
            out_ff <= nxt_avail ? nxt_out : '0;
            avail_ff <= nxt_avail;
            slot_ff <= enable_ff ? nxt_slot : cts_pkg::SLOT_NONE;
        end
    end

    assign logic_out = out_ff;
    assign logic_avail_out = avail_ff;
    assign active_slot_out = slot_ff;

    // write decode
    wire logic wr_ctrl = wr_in && (addr_in == cts_pkg::REG_CTRL);
    wire logic [7:0] slot_off = addr_in - cts_pkg::REG_SLOT_BASE;
    wire logic [7:0] cond_off = addr_in - cts_pkg::REG_COND_BASE;
    wire logic [7:0] const_off = addr_in - cts_pkg::REG_CONST_BASE;
    wire logic wr_slot = wr_in && (addr_in >= cts_pkg::REG_SLOT_BASE) &&
        (slot_off < 8'(cts_pkg::NUM_SLOTS));
    wire logic wr_cond = wr_in && (addr_in >= cts_pkg::REG_COND_BASE) &&
        (cond_off < 8'(NC));
    wire logic wr_const = wr_in && (addr_in >= cts_pkg::REG_CONST_BASE) &&
        (const_off < 8'(NC));
    wire logic [cts_pkg::SRC_W-1:0] w_src1 =
        wdata_in[cts_pkg::F_SRC1_LSB +: cts_pkg::SRC_W];
    wire logic [cts_pkg::SRC_W-1:0] w_src2 =
        wdata_in[cts_pkg::F_SRC2_LSB +: cts_pkg::SRC_W];
    wire logic [2:0] w_op = wdata_in[cts_pkg::F_OP_LSB +: 3];
    wire logic op_legal = (w_op <= 3'(cts_pkg::CMP_LE));
    wire logic src_valid = (w_src1 != cts_pkg::SRC_NOT_USED) &&
        (w_src2 != cts_pkg::SRC_NOT_USED);

    // enable register
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            enable_ff <= 1'b0;
        end else if (wr_ctrl) begin
            enable_ff <= wdata_in[0];
        end
    end

    // slot registers: table number and combiner
    genvar gw;
    generate
        for (gw = 0; gw < cts_pkg::NUM_SLOTS; gw++) begin : g_slot_reg
            localparam logic [2:0] LUT_BASE = ((BLOCK_NUM % 2) == 1) ?
                cts_pkg::LUT_RST_A0 : cts_pkg::LUT_RST_B0;
            localparam logic [2:0] CMB_RST =
                (gw == cts_pkg::NUM_SLOTS - 1) ?
                3'(cts_pkg::CMB_DEFAULT) : 3'(cts_pkg::CMB_AND_ALL);
            always_ff @(posedge clk_in) begin
                if (srst_in) begin
                    lut_sel_ff[gw] <= LUT_BASE + 3'(gw);
                    cmb_ff[gw] <= CMB_RST;
                end else if (wr_slot && slot_off == 8'(gw)) begin
                    lut_sel_ff[gw] <= wdata_in[2:0];
                    if (wdata_in[6:4] <= 3'(cts_pkg::CMB_OR_AND)) begin
                        cmb_ff[gw] <= wdata_in[6:4];
                    end
                end
            end
        end
    endgenerate

    // condition registers and constants
    generate
        for (gw = 0; gw < NC; gw++) begin : g_cond_reg
            always_ff @(posedge clk_in) begin
                if (srst_in) begin
                    src1_ff[gw] <= cts_pkg::SRC_NOT_USED;
                    src2_ff[gw] <= cts_pkg::SRC_NOT_USED;
                    inst1_ff[gw] <= '0;
                    inst2_ff[gw] <= '0;
                    op_ff[gw] <= cts_pkg::CMP_EQ;
                end else if (wr_cond && cond_off == 8'(gw)) begin
                    src1_ff[gw] <= w_src1;
                    src2_ff[gw] <= w_src2;
                    inst1_ff[gw] <=
                        wdata_in[cts_pkg::F_INST1_LSB +: cts_pkg::INST_W];
                    inst2_ff[gw] <=
                        wdata_in[cts_pkg::F_INST2_LSB +: cts_pkg::INST_W];
                    if (src_valid && op_legal) begin
                        op_ff[gw] <= w_op;
                    end else if (!src_valid) begin
                        op_ff[gw] <= cts_pkg::CMP_EQ;
                    end
                end
            end
            always_ff @(posedge clk_in) begin
                if (srst_in) begin
                    const_ff[gw] <= '0;
                end else if (wr_const && const_off == 8'(gw)) begin
                    const_ff[gw] <= wdata_in[DW-1:0];
                end
            end
        end
    endgenerate

    // read mux
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = '0;
        if (addr_in == cts_pkg::REG_CTRL) begin
            rd_mux = {31'h0, enable_ff};
        end else if (addr_in == cts_pkg::REG_STATUS) begin
            rd_mux = {26'h0, hit, avail_ff, slot_ff};
        end else if (addr_in >= cts_pkg::REG_SLOT_BASE &&
                slot_off < 8'(cts_pkg::NUM_SLOTS)) begin
            rd_mux = {25'h0, cmb_ff[slot_off[1:0]], 1'b0,
                lut_sel_ff[slot_off[1:0]]};
        end else if (addr_in >= cts_pkg::REG_COND_BASE &&
                cond_off < 8'(NC)) begin
            rd_mux = {13'h0, op_ff[cond_off[3:0]],
                1'b0, inst2_ff[cond_off[3:0]], src2_ff[cond_off[3:0]],
                1'b0, inst1_ff[cond_off[3:0]], src1_ff[cond_off[3:0]]};
        end else if (addr_in >= cts_pkg::REG_CONST_BASE &&
                const_off < 8'(NC)) begin
            rd_mux = {16'h0, const_ff[const_off[3:0]]};
        end
    end

    // read data stands only the cycle after the strobe
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rdata_out <= '0;
        end else begin
            rdata_out <= rd_in ? rd_mux : '0;
        end
    end
endmodule
`default_nettype wire

// *** cts_selector_assertions.sv ***
// checker: concurrent assertions on the selector ports
`default_nettype none
module cts_selector_checker (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [31:0] rdata_out,
    input wire logic [127:0] lut_data_in,
    input wire logic [7:0] lut_axis_ok_in,
    input wire logic [15:0] logic_out,
    input wire logic logic_avail_out,
    input wire logic [1:0] active_slot_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [127:0] prev_lut_ff;
    logic [7:0] prev_axis_ff;
    logic mirror_hit;
    logic axis_hit;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);
    // table values as the design saw them one edge back
    always_ff @(posedge clk_in) begin
        prev_lut_ff <= lut_data_in;
        prev_axis_ff <= lut_axis_ok_in;
    end
    // output equals one of those values, and that table had its axis
    always_comb begin
        mirror_hit = 1'b0;
        axis_hit = 1'b0;
        for (int k = 0; k < 8; k++) begin
            mirror_hit = mirror_hit | (prev_lut_ff[k*16+:16] == logic_out);
            axis_hit = axis_hit | (prev_axis_ff[k] &&
                prev_lut_ff[k*16+:16] == logic_out);
        end
    end
    AST_NA_ZERO: assert property (
        !logic_avail_out |-> logic_out == 16'h0)
        else $error("data not zero while unavailable");
    AST_NONE_NA: assert property (
        active_slot_out == 2'h3 |-> !logic_avail_out)
        else $error("available with no slot");
    AST_AXIS: assert property (
        logic_avail_out |-> axis_hit)
        else $error("available with no axis source");
    AST_MIRROR: assert property (
        logic_avail_out |-> mirror_hit)
        else $error("output is not a table value");
    AST_RST_OFF: assert property (
        $fell(srst_in) |-> (active_slot_out == 2'h3) [*2])
        else $error("slot selected right after reset");
    AST_STATUS: assert property (
        rd_in && addr_in == 8'h01 |=> rdata_out[2:0] ==
        {$past(logic_avail_out), $past(active_slot_out)})
        else $error("status does not show selection");
    AST_DIS: assert property (
        wr_in && addr_in == 8'h00 && !wdata_in[0] |-> ##2
        active_slot_out == 2'h3)
        else $error("still selecting after disable");
    AST_OP_FORCE: assert property (
        wr_in && addr_in == 8'h20 && wdata_in[3:0] == 4'h0 ##1 !wr_in
        ##1 rd_in && addr_in == 8'h20 |=> rdata_out[18:16] == 3'h0)
        else $error("operator changed without sources");
    cover property (logic_avail_out && active_slot_out == 2'h0);
    cover property (logic_avail_out && active_slot_out == 2'h2);
    cover property (!logic_avail_out && active_slot_out == 2'h2);
endmodule
bind cts_selector cts_selector_checker cts_selector_checker_i (
    .clk_in(clk_in), .srst_in(srst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .lut_data_in(lut_data_in),
    .lut_axis_ok_in(lut_axis_ok_in), .logic_out(logic_out),
    .logic_avail_out(logic_avail_out), .active_slot_out(active_slot_out)
);
`default_nettype wire

// *** cts_far_model.sv ***
// far-side model: block outputs and lookup tables
`default_nettype none
module cts_far_model (
    input wire logic clk_in,
    input wire logic [15:0] arg_in,
    input wire logic err_in,
    input wire logic [7:0] axis_in,
    output logic [255:0] src_data_out,
    output logic [15:0] src_err_out,
    output logic [127:0] lut_data_out,
    output logic [7:0] lut_axis_ok_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] tick_ff = 12'h0;
    // free count keeps table values moving each cycle
    always_ff @(posedge clk_in) begin
        tick_ff <= tick_ff + 12'h1;
    end
    // table n carries its number in the top nibble
    always_comb begin
        for (int n = 0; n < 8; n++)
            lut_data_out[n*16+:16] = {n[3:0], tick_ff};
        src_data_out = {16{~tick_ff[3:0], tick_ff}}; // idle sources toggle
        src_data_out[9*16+:16] = arg_in;
    end
    assign src_err_out = {6'h0, err_in, 9'h0};
    assign lut_axis_ok_out = axis_in;
endmodule
`default_nettype wire

// *** tb_cts_selector.sv ***
// self-checking bench for the conditional table selector
`default_nettype none
module tb_cts_selector;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0, srst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
    logic [7:0] addr_in = 8'h0, axis = 8'hFF, lut_ok;
    logic [31:0] wdata_in = 32'h0, rdata_out;
    logic [15:0] arg = 16'h0, src_err, logic_out, v, k;
    logic err = 1'b0, out_req = 1'b0, rd_d, avail, hit;
    logic [255:0] src_data;
    logic [127:0] lut_data, prev_lut;
    logic [1:0] slot;
    logic [2:0] p;
    logic [63:0] rd_q[$];
    logic [5:0] out_q[$];
    integer seed = 32'h2a4f;
    int failures = 0, comparisons = 0;
    always #5 clk_in = ~clk_in;
    cts_far_model cts_far_model_i (.clk_in(clk_in), .arg_in(arg),
        .err_in(err), .axis_in(axis), .src_data_out(src_data),
        .src_err_out(src_err), .lut_data_out(lut_data),
        .lut_axis_ok_out(lut_ok));
    cts_selector #(.BLOCK_NUM(1)) cts_selector_i (.clk_in(clk_in),
        .srst_in(srst_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .src_data_in(src_data), .src_err_in(src_err),
        .lut_data_in(lut_data), .lut_axis_ok_in(lut_ok),
        .logic_out(logic_out), .logic_avail_out(avail),
        .active_slot_out(slot));
    // shared comparison and report
    task automatic note(input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic cmp_rd(input logic [63:0] n);
        note(n[31:0], rdata_out & n[63:32]);
    endtask
    task automatic cmp_out(input logic [5:0] n);
        note({13'h0, n[5:3], n[3] ? prev_lut[n[2:0]*16+:16] : 16'h0},
            {13'h0, slot, avail, logic_out});
    endtask
    task automatic end_sim();
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // register bus cycles
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
            input logic [31:0] m = 32'hFFFF_FFFF);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        rd_q.push_back({m, e & m});
        @(posedge clk_in);
        rd_in <= 1'b0;
    endtask
    // note expected slot, availability and table, then sample
    task automatic chk(input logic [1:0] s, input logic a,
            input logic [2:0] t);
        out_q.push_back({s, a, t});
        repeat (2) @(posedge clk_in);
        out_req <= 1'b1;
        @(posedge clk_in);
        out_req <= 1'b0;
    endtask
    // read strobe and table values one edge back
    always @(posedge clk_in) begin
        rd_d <= rd_in;
        prev_lut <= lut_data;
    end
    // take the oldest note when a result stands
    always @(negedge clk_in) begin
        if (rd_d === 1'b1)
            cmp_rd(rd_q.pop_front());
        if (out_req)
            cmp_out(out_q.pop_front());
    end
    // watchdog
    initial begin
        repeat (5000) @(posedge clk_in);
        failures++;
        end_sim();
    end
    // main sequence
    initial begin
        repeat (3) @(posedge clk_in);
        srst_in <= 1'b0;
        rd(8'h00, 32'h0);
        rd(8'h10, 32'h10);
        rd(8'h11, 32'h11);
        rd(8'h12, 32'h02);
        rd(8'h20, 32'h0);
        rd(8'h0F, 32'h0);
        chk(2'h3, 1'b0, 3'h0);
        wr(8'h00, 32'h1);
        chk(2'h0, 1'b1, 3'h0);
        rd(8'h01, 32'h4, 32'h7);
        wr(8'h20, 32'h0004_0000);
        rd(8'h20, 32'h0);
        wr(8'h20, 32'h0002_0F11);
        rd(8'h20, 32'h0002_0F11);
        wr(8'h10, 32'h20);
        wr(8'h11, 32'h26);
        for (int o = 0; o < 6; o++) begin
            v = 16'($random(seed));
            k = v ^ 16'($random(seed) & 1);
            wr(8'h40, {16'h0, k});
            wr(8'h20, {13'h0, 3'(o), 16'h0F11});
            @(posedge clk_in);
            arg <= v;
            case (o)
                0: hit = v == k;
                1: hit = v != k;
                2: hit = v > k;
                3: hit = v >= k;
                4: hit = v < k;
                default: hit = v <= k;
            endcase
            chk(hit ? 2'h0 : 2'h2, 1'b1, hit ? 3'h0 : 3'h2);
        end
        for (int c = 0; c < 3; c++)
            wr(8'h20 + 8'(c), 32'h0F11);
        wr(8'h20, 32'h0006_0F11);
        rd(8'h20, 32'h0F11);
        for (int m = 1; m < 5; m++) begin
            wr(8'h10, {25'h0, 3'(m), 4'h0});
            for (int i = 0; i < 8; i++) begin
                p = 3'(i);
                v = 16'($random(seed));
                for (int c = 0; c < 3; c++)
                    wr(8'h40 + 8'(c), {16'h0, v ^ {15'h0, !p[c]}});
                @(posedge clk_in);
                arg <= v;
                case (m)
                    1: hit = &p;
                    2: hit = |p;
                    3: hit = p[0] && p[1] || p[2];
                    default: hit = (p[0] || p[1]) && p[2];
                endcase
                chk(hit ? 2'h0 : 2'h2, 1'b1, hit ? 3'h0 : 3'h2);
            end
        end
        wr(8'h10, 32'h53);
        rd(8'h10, 32'h43);
        wr(8'h10, 32'h10);
        chk(2'h0, 1'b1, 3'h0);
        wr(8'h41, {16'h0, ~v});
        wr(8'h21, 32'h1111);
        chk(2'h0, 1'b1, 3'h0);
        @(posedge clk_in);
        err <= 1'b1;
        chk(2'h2, 1'b1, 3'h2);
        @(posedge clk_in);
        axis <= 8'hFB;
        chk(2'h2, 1'b0, 3'h2);
        wr(8'h00, 32'h0);
        chk(2'h3, 1'b0, 3'h0);
        end_sim();
    end
endmodule
`default_nettype wire
